// ---- rtl/rdpm_top.sv ----
// radio debug pin mux with its avalon-mm register slave
`timescale 1ns/1ps
`include "rdpm_defs.svh"

// Behaviour
// R1 - Three pins each have their own 6-bit select field choosing a radio signal.
// R2 - A nonzero select overrides the function select and forces the pin out.
// R3 - A zero select leaves the pin to its ordinary direction and function.
// R4 - The preamble code drives high while quality exceeds its threshold.
// R5 - The clear-channel code drives high per the selected assessment mode.
// R6 - The carrier-sense code drives high while rssi exceeds its threshold.
// R7 - The crc code shows the last crc match, cleared on receive (re)entry.
// R8 - Two codes put out decided receive bit 1 and bit 0.
// R9 - The tick code puts out the receive symbol strobe.
// R10 - The power-amp code is an active-low level that is low in transmit.
// R11 - The low-noise-amp code is an active-low level that is low in receive.
// R12 - The constant code drives 0, or 1 when the invert bit is set.
// R13 - Software programs only defined codes; the rest are reserved.
// R14 - The crc flag reads as 1 whenever crc checking is disabled.
// R15 - A reserved code still drives the pin as an output at constant low.
module rdpm_top (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic [`RDPM_ADDR_W-1:0]   avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire rdpm_pkg::rdpm_radio_t     radio_i,
  input  wire rdpm_pkg::rdpm_port_t      port_i,
  output rdpm_pkg::rdpm_pad_t            pad_o
);

  // --------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------
  logic                     ack_q;
  logic [31:0]              rdata_q;
  logic [`RDPM_PIN_W-1:0]   pin_cfg_q [`RDPM_NPINS];
  logic [`RDPM_RADIO_W-1:0] radio_cfg_q;
  logic [31:0]              status_w;
  logic [31:0]              rd_mux;

  wire                    req   = avs_read | avs_write;
  wire [`RDPM_IDX_W-1:0]  idx   = avs_address[`RDPM_ADDR_W-1:2];
  wire                    wr_go = avs_write & ack_q;

  // one wait cycle: the request is taken at the second edge it is seen
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] pin0_ext  = {25'h000_0000, pin_cfg_q[0]};
  wire [31:0] pin1_ext  = {25'h000_0000, pin_cfg_q[1]};
  wire [31:0] pin2_ext  = {25'h000_0000, pin_cfg_q[2]};
  wire [31:0] radio_ext = {5'h00, radio_cfg_q};

  // unmapped addresses read as zero and ignore writes
  assign rd_mux = (idx == `RDPM_IDX_PIN0)   ? pin0_ext  :
                  (idx == `RDPM_IDX_PIN1)   ? pin1_ext  :
                  (idx == `RDPM_IDX_PIN2)   ? pin2_ext  :
                  (idx == `RDPM_IDX_RADIO)  ? radio_ext :
                  (idx == `RDPM_IDX_STATUS) ? status_w  :
                  32'h0000_0000;

  wire [31:0] pin0_nx  = be_merge(pin0_ext, avs_writedata, avs_byteenable);
  wire [31:0] pin1_nx  = be_merge(pin1_ext, avs_writedata, avs_byteenable);
  wire [31:0] pin2_nx  = be_merge(pin2_ext, avs_writedata, avs_byteenable);
  wire [31:0] radio_nx = be_merge(radio_ext, avs_writedata,
                                  avs_byteenable);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_cfg_q[0] <= `RDPM_PIN_RST;
      pin_cfg_q[1] <= `RDPM_PIN_RST;
      pin_cfg_q[2] <= `RDPM_PIN_RST;
      radio_cfg_q  <= `RDPM_RADIO_RST;
    end else if (wr_go) begin
      if (idx == `RDPM_IDX_PIN0) begin
        pin_cfg_q[0] <= pin0_nx[`RDPM_PIN_W-1:0];
      end
      if (idx == `RDPM_IDX_PIN1) begin
        pin_cfg_q[1] <= pin1_nx[`RDPM_PIN_W-1:0];
      end
      if (idx == `RDPM_IDX_PIN2) begin
        pin_cfg_q[2] <= pin2_nx[`RDPM_PIN_W-1:0];
      end
      if (idx == `RDPM_IDX_RADIO) begin
        radio_cfg_q <= radio_nx[`RDPM_RADIO_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------
  // radio status conditions
  // --------------------------------------------------------------
  wire [7:0] pqt_thr = radio_cfg_q[`RDPM_PQT_MSB:`RDPM_PQT_LSB];
  wire [7:0] cca_thr = radio_cfg_q[`RDPM_CCAT_MSB:`RDPM_CCAT_LSB];
  wire [7:0] cs_thr  = radio_cfg_q[`RDPM_CST_MSB:`RDPM_CST_LSB];
  wire       crc_en  = radio_cfg_q[`RDPM_CRCEN_BIT];
  rdpm_pkg::rdpm_clear_channel_assess_mode_t clear_channel_assess_mode;
  assign clear_channel_assess_mode = rdpm_pkg::rdpm_clear_channel_assess_mode_t'(
                      radio_cfg_q[`RDPM_CCAM_MSB:`RDPM_CCAM_LSB]);

  // rssi is two's complement, so the two rssi compares are signed
  wire pqt_reached = radio_i.preamble_quality_indicator > pqt_thr; // see R4
  wire carrier     = $signed(radio_i.rssi) > $signed(cs_thr);      // see R6
  wire rssi_low    = $signed(radio_i.rssi) < $signed(cca_thr);

  logic clear_chan;
  always_comb begin
    case (clear_channel_assess_mode) // see R5
      rdpm_pkg::RDPM_CCA_ALWAYS: clear_chan = 1'b1;
      rdpm_pkg::RDPM_CCA_RSSI:   clear_chan = rssi_low;
      rdpm_pkg::RDPM_CCA_NOPKT:  clear_chan = ~radio_i.receiving_packet;
      rdpm_pkg::RDPM_CCA_BOTH:   clear_chan = rssi_low &
                                              ~radio_i.receiving_packet;
      default:                   clear_chan = 1'b0;
    endcase
  end

  // a crc result in the same cycle as a receive restart wins
  logic crc_ok_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crc_ok_q <= 1'b0;
    end else if (radio_i.crc_done) begin
      crc_ok_q <= radio_i.crc_match; // see R7
    end else if (radio_i.rx_start) begin
      crc_ok_q <= 1'b0; // see R7
    end
  end
  wire crc_ok = crc_ok_q | ~crc_en; // see R14

  // both front-end controls are active low
  wire power_amp_powerdown_n_n  = ~radio_i.in_tx; // see R10
  wire low_noise_amp_powerdown_n_n = ~radio_i.in_rx; // see R11

  // --------------------------------------------------------------
  // per-pin selection and pad drive
  // --------------------------------------------------------------
  logic [`RDPM_NPINS-1:0] out_q;
  logic [`RDPM_NPINS-1:0] oe_q;
  logic [`RDPM_NPINS-1:0] out_d;
  logic [`RDPM_NPINS-1:0] oe_d;

  for (genvar g = 0; g < `RDPM_NPINS; g++) begin : g_pin
    wire [`RDPM_SEL_W-1:0] sel =
      pin_cfg_q[g][`RDPM_SEL_MSB:`RDPM_SEL_LSB]; // see R1
    wire inv = pin_cfg_q[g][`RDPM_INV_BIT];
    logic dbg;
    logic defined;

    always_comb begin
      dbg     = 1'b0;
      defined = 1'b1;
      case (sel)
        `RDPM_SEL_PQT:  dbg = pqt_reached;                      // see R4
        `RDPM_SEL_CCA:  dbg = clear_chan;                       // see R5
        `RDPM_SEL_CS:   dbg = carrier;                          // see R6
        `RDPM_SEL_CRC:  dbg = crc_ok;                           // see R7
        `RDPM_SEL_BIT1: dbg = radio_i.receive_decided_bits[1];  // see R8
        `RDPM_SEL_BIT0: dbg = radio_i.receive_decided_bits[0];  // see R8
        `RDPM_SEL_PA:   dbg = power_amp_powerdown_n_n;                          // see R10
        `RDPM_SEL_LNA:  dbg = low_noise_amp_powerdown_n_n;                         // see R11
        `RDPM_SEL_TICK: dbg = radio_i.symbol_tick;              // see R9
        `RDPM_SEL_HW0:  dbg = 1'b0;                             // see R12
        default:        defined = 1'b0;                         // see R15
      endcase
    end

    wire dbg_on  = sel != `RDPM_SEL_OFF;
    wire fn      = port_i.function_select[g];
    wire ord_out = fn ? port_i.periph_out[g] : port_i.gpio_out[g];
    wire ord_oe  = fn ? port_i.periph_oe[g]  : port_i.gpio_dir[g];
    // reserved codes ignore the invert bit so the pin stays low
    wire dbg_lvl = defined ? (dbg ^ inv) : 1'b0; // see R12, R15
    assign out_d[g] = dbg_on ? dbg_lvl : ord_out;   // see R2, R3
    assign oe_d[g]  = dbg_on | ord_oe;              // see R2, R3
  end

  // one process owns the pad registers so each has a single driver
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_q <= 3'h0;
      oe_q  <= 3'h0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pad_o.out = out_q;
  assign pad_o.oe  = oe_q;

  // --------------------------------------------------------------
  // status word
  // --------------------------------------------------------------
  assign status_w = {22'h00_0000, oe_q, out_q,
                     crc_ok, carrier, clear_chan, pqt_reached};

endmodule

// ---- rtl/rdpm_defs.svh ----
// register map, field positions, reset values and signal codes
`ifndef RDPM_DEFS_SVH
`define RDPM_DEFS_SVH

`define RDPM_NPINS        3
`define RDPM_SEL_W        6
`define RDPM_ADDR_W       5
`define RDPM_IDX_W        3
// word index of each register (byte address = index * 4)
`define RDPM_IDX_PIN0     3'h0
`define RDPM_IDX_PIN1     3'h1
`define RDPM_IDX_PIN2     3'h2
`define RDPM_IDX_RADIO    3'h3
`define RDPM_IDX_STATUS   3'h4
// debug_pinN_config fields
`define RDPM_SEL_MSB      5
`define RDPM_SEL_LSB      0
`define RDPM_INV_BIT      6
`define RDPM_PIN_W        7
`define RDPM_PIN_RST      7'h00
// radio configuration fields
`define RDPM_PQT_MSB      7
`define RDPM_PQT_LSB      0
`define RDPM_CCAT_MSB     15
`define RDPM_CCAT_LSB     8
`define RDPM_CST_MSB      23
`define RDPM_CST_LSB      16
`define RDPM_CCAM_MSB     25
`define RDPM_CCAM_LSB     24
`define RDPM_CRCEN_BIT    26
`define RDPM_RADIO_W      27
`define RDPM_RADIO_RST    27'h400_0000
// debug_signal_select codes
`define RDPM_SEL_OFF      6'h00
`define RDPM_SEL_PQT      6'h08
`define RDPM_SEL_CCA      6'h09
`define RDPM_SEL_CS       6'h0e
`define RDPM_SEL_CRC      6'h0f
`define RDPM_SEL_BIT1     6'h16
`define RDPM_SEL_BIT0     6'h17
`define RDPM_SEL_PA       6'h1b
`define RDPM_SEL_LNA      6'h1c
`define RDPM_SEL_TICK     6'h1d
`define RDPM_SEL_HW0      6'h2f

`endif

// ---- rtl/rdpm_pkg.sv ----
// types shared by the radio debug pin mux
package rdpm_pkg;

  typedef enum logic [1:0] {
    RDPM_CCA_ALWAYS,
    RDPM_CCA_RSSI,
    RDPM_CCA_NOPKT,
    RDPM_CCA_BOTH
  } rdpm_clear_channel_assess_mode_t;

  // status levels and strobes coming from the radio state machine
  typedef struct packed {
    logic       in_tx;
    logic       in_rx;
    logic       receiving_packet;
    logic       rx_start;
    logic       crc_done;
    logic       crc_match;
    logic       symbol_tick;
    logic [1:0] receive_decided_bits;
    logic [7:0] preamble_quality_indicator;
    logic [7:0] rssi;
  } rdpm_radio_t;

  // ordinary port settings of the three shared pins
  typedef struct packed {
    logic [2:0] function_select;
    logic [2:0] gpio_out;
    logic [2:0] gpio_dir;
    logic [2:0] periph_out;
    logic [2:0] periph_oe;
  } rdpm_port_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } rdpm_pad_t;

endpackage

// ---- tb/rdpm_checker.sv ----
// concurrent checks on pin 0 of the radio debug pin mux
`timescale 1ns/1ps
`include "rdpm_defs.svh"
module rdpm_checker (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic [`RDPM_ADDR_W-1:0] avs_address,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic                    avs_waitrequest,
  input wire rdpm_pkg::rdpm_radio_t   radio_i,
  input wire rdpm_pkg::rdpm_port_t    port_i,
  input wire rdpm_pkg::rdpm_pad_t     pad_o
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // shadow copies, updated on the same edge a write lands in the design
  logic [6:0] cfg_q;
  logic [7:0] pqt_q;
  wire        wr  = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [5:0]  sel = cfg_q[5:0];
  wire        inv = cfg_q[6];
  wire        o   = pad_o.out[0];
  wire        pq  = radio_i.preamble_quality_indicator > pqt_q;
  wire        oe0 = port_i.function_select[0] ? port_i.periph_oe[0]
                                               : port_i.gpio_dir[0];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= `RDPM_PIN_RST;
      pqt_q <= 8'h00;
    end else if (wr && avs_address[4:2] == `RDPM_IDX_PIN0) begin
      cfg_q <= avs_writedata[6:0];
    end else if (wr && avs_address[4:2] == `RDPM_IDX_RADIO) begin
      pqt_q <= avs_writedata[7:0];
    end
  end
  sequence s_sel(logic [5:0] c);
    sel == c && !inv;
  endsequence
  property p_force; sel != 6'h00 |=> pad_o.oe[0]; endproperty
  a_force: assert property (p_force) else $error("not driven");
  property p_plain; sel == 6'h00 |=> pad_o.oe[0] == $past(oe0); endproperty
  a_plain: assert property (p_plain) else $error("port enable");
  property p_pqt; s_sel(`RDPM_SEL_PQT) |=> o == $past(pq); endproperty
  a_pqt: assert property (p_pqt) else $error("preamble level");
  property p_bit1;
    s_sel(`RDPM_SEL_BIT1) |=> o == $past(radio_i.receive_decided_bits[1]);
  endproperty
  a_bit1: assert property (p_bit1) else $error("data bit");
  property p_tick; s_sel(`RDPM_SEL_TICK) |=> o == $past(radio_i.symbol_tick);
  endproperty
  a_tick: assert property (p_tick) else $error("tick");
  property p_pa; s_sel(`RDPM_SEL_PA) |=> o != $past(radio_i.in_tx); endproperty
  a_pa: assert property (p_pa) else $error("amp control");
  property p_const; sel == `RDPM_SEL_HW0 |=> o == $past(inv); endproperty
  a_const: assert property (p_const) else $error("fixed level");
  property p_resv;
    sel inside {[6'h01:6'h07], [6'h30:6'h3f]} |=> pad_o.oe[0] && !o;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code");
endmodule
bind rdpm_top rdpm_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .radio_i(radio_i), .port_i(port_i),
  .pad_o(pad_o));

// ---- tb/rdpm_far_end.sv ----
// far-end model: the pin wires as outside equipment sees them
`timescale 1ns/1ps
module rdpm_far_end (
  input  wire rdpm_pkg::rdpm_pad_t pad_o,
  output logic [2:0]               level
);
  // board pull-downs: a released pin never shows its last driven value
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      level[k] = pad_o.oe[k] ? pad_o.out[k] : 1'b0;
    end
  end
endmodule

// ---- tb/radio_debug_pin_mux_bench.sv ----
// self-checking bench for the radio debug pin mux
`timescale 1ns/1ps
module radio_debug_pin_mux_bench;
  typedef struct packed {
    logic [6:0] cfg;
    logic [7:0] v;
    logic [4:0] m;
    logic       e;
  } rdpm_row_t;
  // v feeds quality and rssi; m is {tx, rx, tick, bit1, bit0}
  // the last two rows select reserved codes and expect the pin low
  rdpm_row_t rows[19] = '{'{7'h00,8'h00,5'h00,1'h0}, '{7'h08,8'h11,5'h00,1'h1},
    '{7'h08,8'h10,5'h00,1'h0}, '{7'h09,8'hef,5'h00,1'h1},
    '{7'h09,8'hf0,5'h00,1'h0}, '{7'h49,8'hef,5'h00,1'h0},
    '{7'h0e,8'h09,5'h00,1'h1}, '{7'h0e,8'h08,5'h00,1'h0},
    '{7'h16,8'h00,5'h02,1'h1}, '{7'h17,8'h00,5'h02,1'h0},
    '{7'h1b,8'h00,5'h10,1'h0}, '{7'h1b,8'h00,5'h00,1'h1},
    '{7'h1c,8'h00,5'h08,1'h0}, '{7'h1c,8'h00,5'h00,1'h1},
    '{7'h1d,8'h00,5'h04,1'h1}, '{7'h2f,8'h00,5'h00,1'h0},
    '{7'h6f,8'h00,5'h00,1'h1}, '{7'h01,8'h00,5'h00,1'h0},
    '{7'h70,8'h00,5'h1f,1'h0}};
  logic                  sys_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [4:0]            addr = 5'h00;
  logic                  rd = 1'b0;
  logic                  wr = 1'b0;
  logic [31:0]           wdata = 32'h0000_0000;
  logic [31:0]           rdata;
  logic [31:0]           q;
  logic                  waitreq;
  logic [2:0]            level;
  rdpm_pkg::rdpm_radio_t radio = '0;
  rdpm_pkg::rdpm_port_t  port = 15'h7fc0; // peripheral mode, not enabled
  rdpm_pkg::rdpm_pad_t   pad;
  int                    failures = 0;
  int                    n_checks = 0;
  rdpm_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .radio_i(radio), .port_i(port), .pad_o(pad));
  rdpm_far_end far (.pad_o(pad), .level(level));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // called just after a rising edge; returns one edge after the release
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) failures++;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic crc(input logic d, s, e);
    radio.crc_done <= d;
    radio.rx_start <= s;
    @(posedge sys_clk);
    radio.crc_done <= 1'b0;
    radio.rx_start <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(level[0], e, "crc flag");
    @(posedge sys_clk);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    failures++;
    conclude();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 5'h00, 32'h0000_0000);
    chk(q, 32'h0000_0000, "pin0 reset");
    bus(1'b0, 5'h0c, 32'h0000_0000);
    chk(q, 32'h0400_0000, "radio reset");
    bus(1'b1, 5'h14, 32'hffff_ffff);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped");
    $display("test done: registers");
    bus(1'b1, 5'h0c, 32'h0508_f010);
    foreach (rows[i]) begin
      radio.preamble_quality_indicator <= rows[i].v;
      radio.rssi <= rows[i].v;
      {radio.in_tx, radio.in_rx, radio.symbol_tick} <= rows[i].m[4:2];
      radio.receive_decided_bits <= rows[i].m[1:0];
      bus(1'b1, 5'h00, {25'h000_0000, rows[i].cfg});
      @(negedge sys_clk);
      chk(level[0], rows[i].e, "pin0 level");
      chk(pad.oe[0], rows[i].cfg[5:0] != 6'h00, "pin0 enable");
      @(posedge sys_clk);
    end
    $display("test done: codes");
    radio.crc_match <= 1'b1;
    bus(1'b1, 5'h00, 32'h0000_000f);
    crc(1'b1, 1'b0, 1'b1);
    crc(1'b0, 1'b1, 1'b0);
    crc(1'b1, 1'b1, 1'b1);
    radio.crc_match <= 1'b0;
    crc(1'b1, 1'b0, 1'b0);
    bus(1'b1, 5'h0c, 32'h0108_f010);
    crc(1'b0, 1'b0, 1'b1);
    $display("test done: crc");
    bus(1'b1, 5'h04, 32'h0000_006f);
    bus(1'b1, 5'h08, 32'h0000_002f);
    bus(1'b0, 5'h04, 32'h0000_0000);
    chk(q, 32'h0000_006f, "pin1 readback");
    @(negedge sys_clk);
    chk(level, 3'h3, "three pins");
    chk(pad.oe, 3'h7, "three enables");
    @(posedge sys_clk);
    bus(1'b0, 5'h10, 32'h0000_0000);
    chk(q, 32'h0000_03b8, "status word");
    $display("test done: pins");
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 5'h04, 32'h0000_0000);
    chk(q, 32'h0000_0000, "pin1 after reset");
    chk(pad.oe, 3'h0, "enables after reset");
    $display("test done: reset");
    conclude();
  end
endmodule
